//--- rtcpi_core.sv
/*
  Periodic countdown timer and time-update interrupt logic with its
  register set, reached from the serial register port on its own clock.
  Assumes the serial decoder gives a one-cycle write strobe on the serial
  clock edge that completes bit 0 of a byte, and source ticks that are
  one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps

// Functional notes
// - Run bit zero halts countdown and events.
// - Run bit rising restarts from preset value.
// - Timer event sets timer flag, held.
// - Writing zero clears flag, keeps interrupt.
// - Writing one to flag does nothing.
// - Timer event drives interrupt only if enabled.
// - Clearing timer enable releases interrupt immediately.
// - Interrupt line shared with other sources.
// - Timer interrupt auto-releases within set time.
// - Interval equals source period times preset.
// - First interval short by under one period.
// - Countdown starts at enabling byte's last edge.
// - Update event each second or minute.
// - Update flag set per event, held.
// - Update event drives interrupt only if enabled.
// - Update interrupt held fixed time, then released.
// - Clearing update flag keeps interrupt state.
// - Clearing update enable releases interrupt immediately.
// - Register reset bit blocks update events.
// - Update generator always runs; enable only masks.
// - Fixed-zero bits ignore writes, read zero.
// - Source select picks 4096, 64, second, minute.
// - Event on 1-to-0 step, then reload.
// - Update select zero second, one minute.
module rtcpi_core #(
  parameter int RTN_FAST   = rtcpi_pkg::RTN_FAST_CYC,
  parameter int RTN_SLOW   = rtcpi_pkg::RTN_SLOW_CYC,
  parameter int RTN_UPDATE = rtcpi_pkg::RTN_UPDATE_CYC
) (
  // Core clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Serial register port
  input  wire logic                 sclk,
  input  wire logic                 sclk_rst,
  input  wire logic                 wr_stb,
  input  wire rtcpi_pkg::rtcpi_wr_t wr_req,
  input  wire logic [3:0]           rd_addr,
  output logic [7:0]                rd_data,
  // Source ticks
  input  wire logic                 tick_4096,
  input  wire logic                 tick_64,
  input  wire logic                 sec_update,
  input  wire logic                 min_update,
  // Other interrupt sources
  input  wire logic                 ext_irq_req,
  // Open-drain interrupt pin
  output logic                      irq_n_o,
  output logic                      irq_n_oe
);

  // Serial clock side: capture write, toggle, mirror for reads
  rtcpi_pkg::rtcpi_wr_t wr_hold_r;
  logic                 wr_tgl_r;
  logic [7:0]           m_lo_r, m_hi_r, m_ext_r, m_ctl_r;
  logic [2:0]           tf_sync_r, uf_sync_r;
  logic                 tmr_flag_r, upd_flag_r;
  logic [7:0]           rd_nxt;

  always_ff @(posedge sclk) begin
    if (sclk_rst) begin
      wr_hold_r <= '0;
      wr_tgl_r  <= 1'b0;
    end else if (wr_stb) begin
      wr_hold_r <= wr_req;
      wr_tgl_r  <= ~wr_tgl_r;
    end
  end

  always_ff @(posedge sclk) begin
    if (sclk_rst) begin
      m_lo_r  <= rtcpi_pkg::PRESET_RST;
      m_hi_r  <= rtcpi_pkg::PRESET_RST;
      m_ext_r <= rtcpi_pkg::EXT_CTRL_RST;
      m_ctl_r <= rtcpi_pkg::IRQ_CTRL_RST;
    end else if (wr_stb) begin
      if (wr_req.addr == rtcpi_pkg::OFS_PRESET_LO) m_lo_r <= wr_req.data;
      if (wr_req.addr == rtcpi_pkg::OFS_PRESET_HI) m_hi_r <= wr_req.data;
      if (wr_req.addr == rtcpi_pkg::OFS_EXT_CTRL)  m_ext_r <= wr_req.data;
      if (wr_req.addr == rtcpi_pkg::OFS_IRQ_CTRL)  m_ctl_r <= wr_req.data & rtcpi_pkg::IRQ_CTRL_MASK;
    end
  end

  // Flag levels into serial domain
  always_ff @(posedge sclk) begin
    if (sclk_rst) begin
      tf_sync_r <= 3'h0;
      uf_sync_r <= 3'h0;
    end else begin
      tf_sync_r <= {tf_sync_r[1:0], tmr_flag_r};
      uf_sync_r <= {uf_sync_r[1:0], upd_flag_r};
    end
  end

  logic tf_seen_r, uf_seen_r;
  always_ff @(posedge sclk) begin
    if (sclk_rst) begin
      tf_seen_r <= 1'b0;
      uf_seen_r <= 1'b0;
    end else begin
      if (tf_sync_r[1] == tf_sync_r[2]) tf_seen_r <= tf_sync_r[2];
      if (uf_sync_r[1] == uf_sync_r[2]) uf_seen_r <= uf_sync_r[2];
    end
  end

  wire logic [7:0] flags_rd = {2'h0, uf_seen_r, tf_seen_r, 4'h0};

  always_comb begin
    case (rd_addr)
      rtcpi_pkg::OFS_PRESET_LO: rd_nxt = m_lo_r;
      rtcpi_pkg::OFS_PRESET_HI: rd_nxt = m_hi_r;
      rtcpi_pkg::OFS_EXT_CTRL:  rd_nxt = m_ext_r;
      rtcpi_pkg::OFS_FLAGS:     rd_nxt = flags_rd;
      rtcpi_pkg::OFS_IRQ_CTRL:  rd_nxt = m_ctl_r;
      default:                  rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sclk) begin
    if (sclk_rst) rd_data <= 8'h00;
    else          rd_data <= rd_nxt;
  end

  // Core side: write toggle through three flops, filtered
  logic [2:0]           wt_sync_r;
  logic                 wt_seen_r;
  rtcpi_pkg::rtcpi_wr_t wr_c;

  always_ff @(posedge clk) begin
    if (rst) begin
      wt_sync_r <= 3'h0;
      wt_seen_r <= 1'b0;
    end else begin
      wt_sync_r <= {wt_sync_r[1:0], wr_tgl_r};
      if (wt_sync_r[1] == wt_sync_r[2]) wt_seen_r <= wt_sync_r[2];
    end
  end

  wire logic wr_ev = (wt_sync_r[1] == wt_sync_r[2]) && (wt_sync_r[2] != wt_seen_r);
  assign wr_c = wr_hold_r;

  // Everything passed in, so continuous users re-evaluate on each write
  function automatic logic hit(input logic ev, input logic [3:0] a, input logic [3:0] ofs);
    hit = ev && (a == ofs);
  endfunction

  // Core register copies
  logic [7:0] preset_lo_r, preset_hi_r, ext_r, ctl_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      preset_lo_r <= rtcpi_pkg::PRESET_RST;
      preset_hi_r <= rtcpi_pkg::PRESET_RST;
      ext_r       <= rtcpi_pkg::EXT_CTRL_RST;
      ctl_r       <= rtcpi_pkg::IRQ_CTRL_RST;
    end else begin
      if (hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_PRESET_LO)) preset_lo_r <= wr_c.data;
      if (hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_PRESET_HI)) preset_hi_r <= wr_c.data;
      if (hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_EXT_CTRL))  ext_r <= wr_c.data;
      if (hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_IRQ_CTRL))  ctl_r <= wr_c.data & rtcpi_pkg::IRQ_CTRL_MASK;
    end
  end

  wire logic       timer_run           = ext_r[rtcpi_pkg::BIT_RUN];
  wire logic [1:0] timer_src           = {ext_r[rtcpi_pkg::BIT_SRC_HI], ext_r[rtcpi_pkg::BIT_SRC_LO]};
  wire logic       update_period_select = ext_r[rtcpi_pkg::BIT_UPD_SEL];
  wire logic       timer_irq_enable    = ctl_r[rtcpi_pkg::BIT_TMR_IE];
  wire logic       update_irq_enable   = ctl_r[rtcpi_pkg::BIT_UPD_IE];
  wire logic       reg_reset           = ctl_r[rtcpi_pkg::BIT_REG_RESET];
  wire logic [11:0] preset             = {preset_hi_r[3:0], preset_lo_r};

  wire logic run_wr    = hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_EXT_CTRL);
  wire logic run_start = run_wr && !timer_run && wr_c.data[rtcpi_pkg::BIT_RUN];
  wire logic run_stop  = run_wr && !wr_c.data[rtcpi_pkg::BIT_RUN];

  // Source select; slow sources stop under register reset
  logic src_tick;
  always_comb begin
    case (timer_src)
      rtcpi_pkg::SRC_4096: src_tick = tick_4096;
      rtcpi_pkg::SRC_64:   src_tick = tick_64 && !reg_reset;
      rtcpi_pkg::SRC_SEC:  src_tick = sec_update && !reg_reset;
      rtcpi_pkg::SRC_MIN:  src_tick = min_update && !reg_reset;
      default:             src_tick = 1'b0;
    endcase
  end

  // Countdown
  logic [11:0] cnt_r, cnt_nxt;
  logic        tmr_ev;
  always_comb begin
    cnt_nxt = cnt_r;
    tmr_ev  = 1'b0;
    if (run_start) begin
      cnt_nxt = preset;
    end else if (timer_run && src_tick && cnt_r != 12'h000) begin
      if (cnt_r == 12'h001) begin
        tmr_ev  = 1'b1;
        cnt_nxt = preset;
      end else begin
        cnt_nxt = cnt_r - 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) cnt_r <= 12'h000;
    else     cnt_r <= cnt_nxt;
  end

  // Update events, generator always running
  wire logic upd_ev = !reg_reset && (update_period_select ? min_update : sec_update);

  // Flags: set wins over clear, writing one ignored
  wire logic flag_wr  = hit(wr_ev, wr_c.addr, rtcpi_pkg::OFS_FLAGS);
  wire logic tf_clear = flag_wr && !wr_c.data[rtcpi_pkg::BIT_TMR_FLAG];
  wire logic uf_clear = flag_wr && !wr_c.data[rtcpi_pkg::BIT_UPD_FLAG];

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_flag_r <= 1'b0;
      upd_flag_r <= 1'b0;
    end else begin
      if (tmr_ev)        tmr_flag_r <= 1'b1;
      else if (tf_clear) tmr_flag_r <= 1'b0;
      if (upd_ev)        upd_flag_r <= 1'b1;
      else if (uf_clear) upd_flag_r <= 1'b0;
    end
  end

  // Interrupt windows
  logic [rtcpi_pkg::RTN_W-1:0] t_win_r, u_win_r;
  wire logic [rtcpi_pkg::RTN_W-1:0] t_len = (timer_src == rtcpi_pkg::SRC_4096) ?
    rtcpi_pkg::RTN_W'(RTN_FAST) : rtcpi_pkg::RTN_W'(RTN_SLOW);

  always_ff @(posedge clk) begin
    if (rst) begin
      t_win_r <= '0;
    end else if (!timer_irq_enable || run_stop) begin
      t_win_r <= '0;
    end else if (tmr_ev) begin
      t_win_r <= t_len;
    end else if (t_win_r != '0) begin
      t_win_r <= t_win_r - rtcpi_pkg::RTN_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      u_win_r <= '0;
    end else if (!update_irq_enable) begin
      u_win_r <= '0;
    end else if (upd_ev) begin
      u_win_r <= rtcpi_pkg::RTN_W'(RTN_UPDATE);
    end else if (u_win_r != '0) begin
      u_win_r <= u_win_r - rtcpi_pkg::RTN_W'(1);
    end
  end

  // Open-drain drive: low level, enable while any window active
  logic irq_oe_r;
  wire logic t_win_nz = (t_win_r != '0);
  wire logic u_win_nz = (u_win_r != '0);
  always_ff @(posedge clk) begin
    if (rst) irq_oe_r <= 1'b0;
    else     irq_oe_r <= (t_win_nz || u_win_nz || ext_irq_req);
  end

  assign irq_n_o  = 1'b0;
  assign irq_n_oe = irq_oe_r;

endmodule // rtcpi_core

//--- rtcpi_pkg.sv
/*
  Package for the periodic timer and time-update interrupt block:
  register offsets, field positions, reset values, timing constants
  and the register-write carrier type.
  Assumes a 125 MHz core clock and a serial register port on its own clock.
*/
package rtcpi_pkg;

  // Register offsets
  localparam logic [3:0] OFS_PRESET_LO = 4'hb;
  localparam logic [3:0] OFS_PRESET_HI = 4'hc;
  localparam logic [3:0] OFS_EXT_CTRL  = 4'hd;
  localparam logic [3:0] OFS_FLAGS     = 4'he;
  localparam logic [3:0] OFS_IRQ_CTRL  = 4'hf;

  // Extension control fields
  localparam int BIT_SRC_LO  = 0;
  localparam int BIT_SRC_HI  = 1;
  localparam int BIT_RUN     = 4;
  localparam int BIT_UPD_SEL = 5;

  // Flag fields
  localparam int BIT_TMR_FLAG = 4;
  localparam int BIT_UPD_FLAG = 5;

  // Interrupt control fields
  localparam int BIT_REG_RESET = 0;
  localparam int BIT_TMR_IE    = 4;
  localparam int BIT_UPD_IE    = 5;

  // Writable masks; zero bits are write-protected and read zero
  localparam logic [7:0] IRQ_CTRL_MASK = 8'hf9;
  localparam logic [7:0] FLAGS_MASK    = 8'h30;

  // Reset values
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESET_RST   = 8'h00;

  // Source select codes
  localparam logic [1:0] SRC_4096 = 2'h0;
  localparam logic [1:0] SRC_64   = 2'h1;
  localparam logic [1:0] SRC_SEC  = 2'h2;
  localparam logic [1:0] SRC_MIN  = 2'h3;

  // Auto-release times in ns and core clock rate
  localparam longint CLK_MHZ         = 125;
  localparam longint RTN_FAST_NS     = 122000;
  localparam longint RTN_SLOW_NS     = 7812500;
  localparam longint RTN_UPDATE_NS   = 7182500;
  // Longest times round down
  localparam int RTN_FAST_CYC   = int'((RTN_FAST_NS * CLK_MHZ) / 1000);
  localparam int RTN_SLOW_CYC   = int'((RTN_SLOW_NS * CLK_MHZ) / 1000);
  localparam int RTN_UPDATE_CYC = int'((RTN_UPDATE_NS * CLK_MHZ) / 1000);

  localparam int RTN_W = 20;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rtcpi_wr_t;

endpackage

//--- rtcpi_props.sv
/* Checker for the interrupt block: pin level, auto-release bound, readback zeros.
   Bound into rtcpi_core; sees its ports only. */
`timescale 1ns/1ps
module rtcpi_props #(
  parameter int RTN_SLOW = 40
) (
  // Clocks and resets
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sclk,
  input wire logic       sclk_rst,
  // Read port
  input wire logic [3:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Sources and pin
  input wire logic       tick_4096,
  input wire logic       tick_64,
  input wire logic       sec_update,
  input wire logic       min_update,
  input wire logic       ext_irq_req,
  input wire logic       irq_n_o,
  input wire logic       irq_n_oe
);
  logic        any_src;
  logic [19:0] low_cnt_r;
  logic [19:0] low_cnt_nxt;
  assign any_src = tick_4096 | tick_64 | sec_update | min_update | ext_irq_req;
  // Cycles the pin stays low with no new cause
  assign low_cnt_nxt = (any_src || !irq_n_oe) ? 20'h0 : low_cnt_r + 20'h1;
  always_ff @(posedge clk) begin
    low_cnt_r <= rst ? 20'h0 : low_cnt_nxt;
  end
  od_data_low_a: assert property (@(posedge clk) disable iff (rst) irq_n_o == 1'b0)
    else $error("pin data not low");
  ext_hold_a: assert property (@(posedge clk) disable iff (rst) ext_irq_req [*3] |=> irq_n_oe)
    else $error("other source not driving pin");
  ext_fall_a: assert property (@(posedge clk) disable iff (rst) $fell(irq_n_oe) |->
    !$past(ext_irq_req) || !$past(ext_irq_req, 2)) else $error("pin released under other source");
  oe_cause_a: assert property (@(posedge clk) disable iff (rst) $rose(irq_n_oe) |->
    $past(ext_irq_req) || $past(any_src, 2)) else $error("pin low without event");
  auto_rel_a: assert property (@(posedge clk) disable iff (rst) low_cnt_r <= RTN_SLOW + 4)
    else $error("pin not released in time");
  ctrl_zero_a: assert property (@(posedge sclk) disable iff (sclk_rst)
    $past(rd_addr) == rtcpi_pkg::OFS_IRQ_CTRL |-> (rd_data & ~rtcpi_pkg::IRQ_CTRL_MASK) == 8'h00)
    else $error("control fixed bits not zero");
  flag_zero_a: assert property (@(posedge sclk) disable iff (sclk_rst)
    $past(rd_addr) == rtcpi_pkg::OFS_FLAGS |-> (rd_data & ~rtcpi_pkg::FLAGS_MASK) == 8'h00)
    else $error("flag fixed bits not zero");
  unmap_zero_a: assert property (@(posedge sclk) disable iff (sclk_rst)
    $past(rd_addr) < rtcpi_pkg::OFS_PRESET_LO |-> rd_data == 8'h00) else $error("unmapped read not zero");
endmodule // rtcpi_props

bind rtcpi_core rtcpi_props #(.RTN_SLOW(RTN_SLOW)) rtcpi_props_inst (.clk(clk), .rst(rst), .sclk(sclk),
  .sclk_rst(sclk_rst), .rd_addr(rd_addr), .rd_data(rd_data), .tick_4096(tick_4096), .tick_64(tick_64),
  .sec_update(sec_update), .min_update(min_update), .ext_irq_req(ext_irq_req), .irq_n_o(irq_n_o),
  .irq_n_oe(irq_n_oe));

//--- rtcpi_host.sv
/* Host model on the serial register port: gated serial clock, byte writes, reads.
   Assumes the core takes a byte at the rising edge that carries wr_stb. */
`timescale 1ns/1ps
module rtcpi_host (
  // Serial register port
  output logic                 sclk,
  output logic                 sclk_rst,
  output logic                 wr_stb,
  output rtcpi_pkg::rtcpi_wr_t wr_req,
  output logic [3:0]           rd_addr,
  input  wire logic [7:0]      rd_data
);
  initial begin
    sclk = 1'b0;
    sclk_rst = 1'b1;
    wr_stb = 1'b0;
    wr_req = '0;
    rd_addr = 4'h0;
  end
  // Clock stands still low between frames
  task automatic pulse(input int n);
    repeat (n) begin
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
  endtask
  task automatic reset_port();
    #3 pulse(2);
    sclk_rst = 1'b0;
    pulse(1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_req = '{addr: a, data: d};
    wr_stb = 1'b1;
    pulse(1);
    wr_stb = 1'b0;
    wr_req = ~wr_req;
    pulse(2);
  endtask
  // Mirror needs a few edges to follow the core
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    rd_addr = a;
    pulse(6);
    #14 q = rd_data;
  endtask
endmodule // rtcpi_host

//--- rtc_periodic_and_update_interrupts_tb_top.sv
/* Self-checking bench for rtcpi_core: registers, timer sources, flags, pin windows.
   Uses the host model for the serial port and drives source ticks itself. */
`timescale 1ns/1ps
module rtc_periodic_and_update_interrupts_tb_top;
  localparam logic [3:0] A_CTL = rtcpi_pkg::OFS_IRQ_CTRL;
  localparam logic [3:0] A_FLG = rtcpi_pkg::OFS_FLAGS;
  localparam logic [3:0] A_EXT = rtcpi_pkg::OFS_EXT_CTRL;
  logic                 clk;
  logic                 rst;
  logic [3:0]           src;
  logic                 ext_irq_req;
  logic                 sclk;
  logic                 sclk_rst;
  logic                 wr_stb;
  rtcpi_pkg::rtcpi_wr_t wr_req;
  logic [3:0]           rd_addr;
  logic [7:0]           rd_data;
  logic                 irq_n_o;
  logic                 irq_n_oe;
  logic [7:0]           q;
  int                   error_cnt = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  rtcpi_core #(.RTN_FAST(20), .RTN_SLOW(40), .RTN_UPDATE(30)) rtcpi_core_inst (.clk(clk), .rst(rst),
    .sclk(sclk), .sclk_rst(sclk_rst), .wr_stb(wr_stb), .wr_req(wr_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .tick_4096(src[0]), .tick_64(src[1]), .sec_update(src[2]), .min_update(src[3]),
    .ext_irq_req(ext_irq_req), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  rtcpi_host rtcpi_host_inst (.sclk(sclk), .sclk_rst(sclk_rst), .wr_stb(wr_stb), .wr_req(wr_req),
    .rd_addr(rd_addr), .rd_data(rd_data));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] d);
    rtcpi_host_inst.wr(a, d);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rtcpi_host_inst.rd(a, q);
    chk(q, exp);
  endtask
  task automatic tk(input logic [3:0] v, input int n);
    repeat (n) begin
      @(negedge clk) src = v;
      @(negedge clk) src = 4'h0;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic pin(input logic exp, input int n);
    repeat (n) begin
      if (irq_n_oe === exp) break;
      @(negedge clk);
    end
    chk({7'h0, irq_n_oe}, {7'h0, exp});
  endtask
  task automatic t_regs();
    rchk(A_CTL, rtcpi_pkg::IRQ_CTRL_RST);
    w(A_CTL, 8'hce);
    rchk(A_CTL, 8'hce & rtcpi_pkg::IRQ_CTRL_MASK);
    w(A_FLG, 8'hff);
    rchk(A_FLG, 8'h00);
    rchk(4'h0, 8'h00);
    w(A_EXT, 8'hcc);
    rchk(A_EXT, 8'hcc);
    w(A_CTL, 8'h10);
    w(A_EXT, 8'h00);
    w(rtcpi_pkg::OFS_PRESET_LO, 8'h03);
    w(rtcpi_pkg::OFS_PRESET_HI, 8'h00);
    @(negedge clk) ext_irq_req = 1'b1;
    pin(1'b1, 6);
    @(negedge clk) ext_irq_req = 1'b0;
    pin(1'b0, 6);
  endtask
  task automatic t_src();
    for (int s = 0; s < 4; s++) begin
      w(A_EXT, 8'h00);
      w(A_EXT, 8'h10 | 8'(s));
      tk(4'(1 << ((s + 1) % 4)), 3);
      pin(1'b0, 1);
      tk(4'(1 << s), 3);
      pin(1'b1, 4);
    end
  endtask
  task automatic t_timer();
    w(A_EXT, 8'h00);
    w(A_FLG, 8'h00);
    w(A_EXT, 8'h10);
    tk(4'h1, 3);
    pin(1'b1, 4);
    pin(1'b0, 24);
    rchk(A_FLG, 8'h10);
    w(A_FLG, 8'h00);
    rchk(A_FLG, 8'h00);
    tk(4'h1, 3);
    pin(1'b1, 4);
    w(A_CTL, 8'h00);
    chk({7'h0, irq_n_oe}, 8'h00);
    tk(4'h1, 3);
    pin(1'b0, 1);
    rchk(A_FLG, 8'h10);
    w(A_CTL, 8'h10);
    w(A_FLG, 8'h00);
    tk(4'h1, 2);
    w(A_EXT, 8'h00);
    tk(4'h1, 3);
    rchk(A_FLG, 8'h00);
    w(A_EXT, 8'h10);
    tk(4'h1, 2);
    pin(1'b0, 1);
    tk(4'h1, 1);
    pin(1'b1, 4);
    w(A_EXT, 8'h00);
    chk({7'h0, irq_n_oe}, 8'h00);
  endtask
  task automatic t_update();
    w(A_CTL, 8'h20);
    w(A_FLG, 8'h00);
    tk(4'h8, 1);
    pin(1'b0, 1);
    tk(4'h4, 1);
    pin(1'b1, 4);
    w(A_FLG, 8'h00);
    chk({7'h0, irq_n_oe}, 8'h01);
    w(A_CTL, 8'h00);
    chk({7'h0, irq_n_oe}, 8'h00);
    tk(4'h4, 1);
    pin(1'b0, 1);
    rchk(A_FLG, 8'h20);
    w(A_FLG, 8'h00);
    w(A_EXT, 8'h20);
    w(A_CTL, 8'h20);
    tk(4'h4, 1);
    pin(1'b0, 1);
    tk(4'h8, 1);
    pin(1'b1, 4);
    repeat (20) @(negedge clk);
    chk({7'h0, irq_n_oe}, 8'h01);
    pin(1'b0, 14);
    w(A_CTL, 8'h01);
    w(A_FLG, 8'h00);
    tk(4'h8, 1);
    rchk(A_FLG, 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    src = 4'h0;
    ext_irq_req = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rtcpi_host_inst.reset_port();
    t_regs();
    t_src();
    t_timer();
    t_update();
    final_report();
  end
endmodule // rtc_periodic_and_update_interrupts_tb_top
